// File: gpio_map_pkg.sv
package gpio_map_pkg;
    // Register addresses
    localparam logic [7:0] PIN10_FUNC_ADDR = 8'hEA;
    localparam logic [7:0] PIN11_FUNC_ADDR = 8'hEB;
    localparam logic [7:0] SPUR_ADDR       = 8'hF7;
    // Reset values
    localparam logic [7:0] PIN_FUNC_RESET  = 8'h00;
    localparam logic [7:0] SPUR_RESET      = 8'h00;
    // Field layout of a pin-function register
    localparam int DIR_BIT     = 7;
    localparam int INDEX_MSB   = 6;
    localparam int INDEX_WIDTH = 7;
    localparam int TABLE_BITS  = 128;
    // Direction encodings
    localparam logic DIR_CONTROL = 1'b0;
    localparam logic DIR_STATUS  = 1'b1;
    // Reconfiguration time after a spur setting change
    localparam int CLK_MHZ         = 250;
    localparam int RECONFIG_MS     = 200;
    localparam int RECONFIG_CYCLES = RECONFIG_MS * 1000 * CLK_MHZ;
endpackage

// File: gpio_pin_map.sv
`timescale 1ns/1ps
// One general pin routed to one bit of the control or status table
module gpio_pin_map (
    input  wire logic         clk_i,
    input  wire logic         resetn_i,
    input  wire logic [7:0]   func_i,
    input  wire logic         pin_i,
    input  wire logic [127:0] status_table_i,
    output logic              pin_o,
    output logic              pin_oe_o,
    output logic              ctrl_valid_o,
    output logic [6:0]        ctrl_index_o,
    output logic              ctrl_level_o
);
    logic       sync_a;  // First stage, read only by sync_b
    logic       sync_b;
    logic       sync_c;
    logic       level;   // Accepted pin level
    logic       dir;
    logic [6:0] index;

    assign dir   = func_i[gpio_map_pkg::DIR_BIT];
    assign index = func_i[gpio_map_pkg::INDEX_MSB:0];

    // Three-stage synchroniser; change taken once stages two and three agree
    always_ff @(posedge clk_i) begin
        if (!resetn_i) begin
            sync_a <= 1'b0;
            sync_b <= 1'b0;
            sync_c <= 1'b0;
            level  <= 1'b0;
        end else begin
            sync_a <= pin_i;
            sync_b <= sync_a;
            sync_c <= sync_b;
            if (sync_b == sync_c) begin
                level <= sync_c;
            end
        end
    end

    // Pin drive and control contribution
    always_ff @(posedge clk_i) begin
        if (!resetn_i) begin
            pin_o        <= 1'b0;
            pin_oe_o     <= 1'b0;
            ctrl_valid_o <= 1'b0;
            ctrl_index_o <= 7'h00;
            ctrl_level_o <= 1'b0;
        end else begin
            pin_oe_o     <= (dir == gpio_map_pkg::DIR_STATUS);
            pin_o        <= status_table_i[index];
            ctrl_valid_o <= (dir == gpio_map_pkg::DIR_CONTROL)
                            && (func_i != gpio_map_pkg::PIN_FUNC_RESET);
            ctrl_index_o <= index;
            ctrl_level_o <= level;
        end
    end
endmodule

// File: gpio_table_mapping_regs.sv
`timescale 1ns/1ps
module gpio_table_mapping_regs (
    input  wire logic         clk_i,
    input  wire logic         resetn_i,
    // Register access port
    input  wire logic         reg_write_i,
    input  wire logic [7:0]   reg_addr_i,
    input  wire logic [7:0]   reg_wdata_i,
    output logic [7:0]        reg_rdata_o,
    output logic              reconfig_busy_o,
    // Pins
    input  wire logic         general_pin_ten_i,
    output logic              general_pin_ten_o,
    output logic              general_pin_ten_oe_o,
    input  wire logic         general_pin_eleven_i,
    output logic              general_pin_eleven_o,
    output logic              general_pin_eleven_oe_o,
    // Tables and spur setting
    input  wire logic [127:0] status_table_i,
    input  wire logic [127:0] control_table_i,
    output logic [127:0]      control_table_o,
    output logic [7:0]        spur_setting_o
);
    // Reconfiguration length in clock cycles
    localparam int RECONFIG_CYCLES = gpio_map_pkg::RECONFIG_CYCLES;

    logic [7:0]  pin10_function_select;   // Pin ten mapping
    logic [7:0]  pin11_function_select;   // Pin eleven mapping
    logic [7:0]  spur_reduction_setting;  // Spur reduction value
    logic [27:0] reconfig_count;          // Cycles left of reconfiguration
    logic        pin10_direction_choice;
    logic        pin11_direction_choice;
    logic        valid10;
    logic        valid11;
    logic [6:0]  index10;
    logic [6:0]  pin11_bit_index;
    logic        level10;
    logic        level11;

    assign pin10_direction_choice = pin10_function_select[gpio_map_pkg::DIR_BIT];
    assign pin11_direction_choice = pin11_function_select[gpio_map_pkg::DIR_BIT];

    // Register writes; ignored while reconfiguring
    // Writes in the busy period are dropped, not queued; the host
    // must wait the period out, so nothing is lost in normal use
    always_ff @(posedge clk_i) begin
        if (!resetn_i) begin
            pin10_function_select  <= gpio_map_pkg::PIN_FUNC_RESET;
            pin11_function_select  <= gpio_map_pkg::PIN_FUNC_RESET;
            spur_reduction_setting <= gpio_map_pkg::SPUR_RESET;
        end else if (reg_write_i && !reconfig_busy_o) begin
            unique case (reg_addr_i)
                gpio_map_pkg::PIN10_FUNC_ADDR: pin10_function_select  <= reg_wdata_i;
                gpio_map_pkg::PIN11_FUNC_ADDR: pin11_function_select  <= reg_wdata_i;
                gpio_map_pkg::SPUR_ADDR:       spur_reduction_setting <= reg_wdata_i;
                default: ;  // Unmapped address ignored
            endcase
        end
    end

    // Reconfiguration timer, started only by a real change
    // Rewriting the same value starts no busy period, so a host
    // that restores a setting loses no time
    always_ff @(posedge clk_i) begin
        if (!resetn_i) begin
            reconfig_count <= 28'h0000000;
        end else if (reg_write_i && !reconfig_busy_o
                     && reg_addr_i == gpio_map_pkg::SPUR_ADDR
                     && reg_wdata_i != spur_reduction_setting) begin
            reconfig_count <= 28'(RECONFIG_CYCLES);
        end else if (reconfig_count != 28'h0000000) begin
            reconfig_count <= reconfig_count - 28'h0000001;
        end
    end

    // busy while counting
    // Counter in flip-flops; busy is a combinational decode of it, not registered
    assign reconfig_busy_o = (reconfig_count != 28'h0000000);

    // Read data from flip-flops; unmapped reads as zero
    // Data follows the address one cycle later; this logic would
    // also answer in the busy period, though the host must not ask
    always_ff @(posedge clk_i) begin
        if (!resetn_i) begin
            reg_rdata_o <= 8'h00;
        end else begin
            unique case (reg_addr_i)
                gpio_map_pkg::PIN10_FUNC_ADDR: reg_rdata_o <= pin10_function_select;
                gpio_map_pkg::PIN11_FUNC_ADDR: reg_rdata_o <= pin11_function_select;
                gpio_map_pkg::SPUR_ADDR:       reg_rdata_o <= spur_reduction_setting;
                default:                       reg_rdata_o <= 8'h00;
            endcase
        end
    end

    // Spur value goes straight to the synthesizer logic
    assign spur_setting_o = spur_reduction_setting;

    // Pin ten mapping
    // pin ten through its mapper
    // Both mappers share the same status table input
    gpio_pin_map u_pin10 (
        .clk_i          (clk_i),
        .resetn_i       (resetn_i),
        .func_i         (pin10_function_select),
        .pin_i          (general_pin_ten_i),
        .status_table_i (status_table_i),
        .pin_o          (general_pin_ten_o),
        .pin_oe_o       (general_pin_ten_oe_o),
        .ctrl_valid_o   (valid10),
        .ctrl_index_o   (index10),
        .ctrl_level_o   (level10)
    );

    // Pin eleven mapping
    // pin eleven through its mapper
    gpio_pin_map u_pin11 (
        .clk_i          (clk_i),
        .resetn_i       (resetn_i),
        .func_i         (pin11_function_select),
        .pin_i          (general_pin_eleven_i),
        .status_table_i (status_table_i),
        .pin_o          (general_pin_eleven_o),
        .pin_oe_o       (general_pin_eleven_oe_o),
        .ctrl_valid_o   (valid11),
        .ctrl_index_o   (pin11_bit_index),
        .ctrl_level_o   (level11)
    );

    // Limitation: with 0x00 meaning unused, no pin feeds control bit 0;
    // status bit 0 stays reachable through 0x80
    // Overlay pin levels on the control table; pin eleven wins a shared bit
    always_comb begin
        control_table_o = control_table_i;
        if (valid10) begin
            control_table_o[index10] = level10;
        end
        // Pin eleven applied last, so it wins a shared index
        if (valid11) begin
            control_table_o[pin11_bit_index] = level11;
        end
    end

    // Assertions
    // Each property guards one rule; the tag sits on the label line
    a_reset_zero_regs: assert property (@(posedge clk_i)
        $rose(resetn_i) |-> pin10_function_select == 8'h00
            && pin11_function_select == 8'h00 && spur_reduction_setting == 8'h00)
        else $error("registers not zero after reset");

    a_spur_starts_busy: assert property (@(posedge clk_i) disable iff (!resetn_i)
        $past(resetn_i) && $changed(spur_reduction_setting) |-> reconfig_busy_o
            && reconfig_count == 28'(RECONFIG_CYCLES))
        else $error("spur change did not start reconfiguration");

    a_busy_blocks_writes: assert property (@(posedge clk_i) disable iff (!resetn_i)
        reconfig_busy_o |=> $stable(pin10_function_select)
            && $stable(pin11_function_select) && $stable(spur_reduction_setting))
        else $error("write accepted while reconfiguring");

    a_status_pin_drive: assert property (@(posedge clk_i) disable iff (!resetn_i)
        pin10_direction_choice && $stable(pin10_function_select)
            |=> general_pin_ten_oe_o)
        else $error("status pin ten not driven");

    a_control_pin_float: assert property (@(posedge clk_i) disable iff (!resetn_i)
        !pin11_direction_choice && $stable(pin11_function_select)
            |=> !general_pin_eleven_oe_o)
        else $error("control pin eleven driven");

    a_status_bit_out: assert property (@(posedge clk_i) disable iff (!resetn_i)
        pin10_direction_choice |=> general_pin_ten_o
            == $past(status_table_i[pin10_function_select[6:0]]))
        else $error("pin ten not following status bit");

    a_index_routed: assert property (@(posedge clk_i) disable iff (!resetn_i)
        $stable(pin11_function_select) |=> pin11_bit_index
            == $past(pin11_function_select[6:0]))
        else $error("pin eleven index wrong");

    a_control_bit_in: assert property (@(posedge clk_i) disable iff (!resetn_i)
        valid11 |-> control_table_o[pin11_bit_index] == level11)
        else $error("control bit not driven by pin eleven");

    a_busy_count_steps: assert property (@(posedge clk_i) disable iff (!resetn_i)
        reconfig_busy_o |=> reconfig_count == $past(reconfig_count) - 28'h0000001)
        else $error("reconfiguration counter skipped");

    a_busy_needs_change: assert property (@(posedge clk_i) disable iff (!resetn_i)
        $rose(reconfig_busy_o) |-> $changed(spur_reduction_setting))
        else $error("busy started without a spur change");

    a_unused_pin_idle: assert property (@(posedge clk_i) disable iff (!resetn_i)
        pin10_function_select == gpio_map_pkg::PIN_FUNC_RESET
            |=> !valid10 && !general_pin_ten_oe_o)
        else $error("unused pin ten still mapped");

    a_pin_eleven_status: assert property (@(posedge clk_i) disable iff (!resetn_i)
        pin11_direction_choice |=> general_pin_eleven_o
            == $past(status_table_i[pin11_function_select[6:0]]))
        else $error("pin eleven not following status bit");

    a_table_passthrough: assert property (@(posedge clk_i) disable iff (!resetn_i)
        !valid10 && !valid11 |-> control_table_o == control_table_i)
        else $error("control table changed with no control pin");
endmodule

// File: host_model.sv
`timescale 1ns/1ps
// Host side of the register port
module host_model (
    input  wire logic  clk_i,
    output logic       reg_write_o,
    output logic [7:0] reg_addr_o,
    output logic [7:0] reg_wdata_o
);
    // Idle bus at time zero
    initial begin
        reg_write_o = 1'b0;
        reg_addr_o  = 8'h00;
        reg_wdata_o = 8'h00;
    end
    // caller waits out busy
    // One-cycle write; data inverted after
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk_i);
        reg_write_o <= 1'b1;
        reg_addr_o  <= a;
        reg_wdata_o <= d;
        @(posedge clk_i);
        reg_write_o <= 1'b0;
        reg_wdata_o <= ~d;
    endtask
    // Present a read address
    task automatic addr(input logic [7:0] a);
        @(posedge clk_i);
        reg_addr_o <= a;
    endtask
endmodule

// File: tb_top.sv
`timescale 1ns/1ps
module tb_top;
    logic clk_i = 1'b0, resetn_i, p10, p11, chk, we;
    logic [7:0] adr, wd, rdata, spur, a, b;
    logic [127:0] st, ct, cto, c;
    logic busy, o10, oe10, o11, oe11;
    logic [1:0] e10;
    logic [31:0] seed = 32'h1649;    // Fixed seed
    int n_errors = 0, samples_checked = 0, sel_q[$];
    logic [127:0] exp_q[$];
    string nm[6] = '{"rdata", "pin10", "pin11", "ctl_tbl", "busy", "spur"};
    always #2 clk_i = ~clk_i;
    host_model i_host (.clk_i(clk_i), .reg_write_o(we), .reg_addr_o(adr), .reg_wdata_o(wd));
    gpio_table_mapping_regs i_dut (.clk_i(clk_i), .resetn_i(resetn_i), .reg_write_i(we),
        .reg_addr_i(adr), .reg_wdata_i(wd), .reg_rdata_o(rdata), .reconfig_busy_o(busy),
        .general_pin_ten_i(p10), .general_pin_ten_o(o10), .general_pin_ten_oe_o(oe10),
        .general_pin_eleven_i(p11), .general_pin_eleven_o(o11),
        .general_pin_eleven_oe_o(oe11), .status_table_i(st), .control_table_i(ct),
        .control_table_o(cto), .spur_setting_o(spur));
    function automatic logic [31:0] xs();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction
    // Note an expected value for the monitor
    task automatic ex(input int k, input logic [127:0] e);
        sel_q.push_back(k);
        exp_q.push_back(e);
    endtask
    // Ask the monitor to compare at the next edge
    task automatic snap();
        chk <= 1'b1;
        @(posedge clk_i);
        chk <= 1'b0;
    endtask
    task automatic rd(input logic [7:0] ad, input logic [7:0] e);
        i_host.addr(ad);
        @(posedge clk_i);
        ex(0, e);
        snap();
    endtask
    // Compare one seen value against its note
    task automatic check(input string name, input logic [127:0] seen,
                         input logic [127:0] expv);
        samples_checked++;
        if (seen !== expv) begin
            n_errors++;
            $display("[ERR] %s exp %h seen %h", name, expv, seen);
        end
    endtask
    task automatic end_sim();
        $display("checks %0d errors %0d", samples_checked, n_errors);
        if (n_errors == 0 && samples_checked > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask
    // Monitor: every pending note, oldest first, against what the outputs show
    always @(posedge clk_i) begin
        logic [127:0] s;
        int k;
        if (chk === 1'b1) while (sel_q.size() > 0) begin
            k = sel_q.pop_front();
            s = k == 0 ? 128'(rdata) : k == 1 ? 128'({oe10, o10 & oe10}) :
                k == 2 ? 128'({oe11, o11 & oe11}) : k == 3 ? cto :
                k == 4 ? 128'(busy) : 128'(spur);
            check(nm[k], s, exp_q.pop_front());
        end
    end
    // Watchdog on the whole run
    initial begin
        repeat (20000) @(posedge clk_i);
        n_errors++;
        end_sim();
    end
    initial begin
        logic [7:0] f10[3] = '{8'h7F, 8'h80, 8'h05};    // Index 127, 0, shared
        logic [7:0] f11[3] = '{8'hFF, 8'h7F, 8'h05};
        {resetn_i, p10, p11, chk, st, ct} = '0;
        repeat (20) @(posedge clk_i);
        resetn_i <= 1'b1;
        rd(gpio_map_pkg::PIN10_FUNC_ADDR, 8'h00);
        rd(gpio_map_pkg::PIN11_FUNC_ADDR, 8'h00);
        rd(gpio_map_pkg::SPUR_ADDR, 8'h00);
        for (int i = 0; i < 8; i++) begin
            a = i < 3 ? f10[i] : 8'(xs());
            b = i < 3 ? f11[i] : 8'(xs());
            @(posedge clk_i);
            st <= {xs(), xs(), xs(), xs()};
            ct <= {xs(), xs(), xs(), xs()};
            {p10, p11} <= 2'(xs());
            i_host.wr(gpio_map_pkg::PIN10_FUNC_ADDR, a);
            i_host.wr(gpio_map_pkg::PIN11_FUNC_ADDR, b);
            repeat (8) @(posedge clk_i);
            c = ct;
            if (!a[7] && a != 8'h00) c[a[6:0]] = p10;
            if (!b[7] && b != 8'h00) c[b[6:0]] = p11;
            e10 = a[7] ? {1'b1, st[a[6:0]]} : 2'b00;
            ex(1, e10);
            ex(2, b[7] ? {1'b1, st[b[6:0]]} : 2'b00);
            ex(3, c);
            snap();
            rd(gpio_map_pkg::PIN10_FUNC_ADDR, a);
        end
        // Unmapped place: write lost, reads zero
        i_host.wr(8'h10, 8'hFF);
        rd(8'h10, 8'h00);
        i_host.wr(gpio_map_pkg::SPUR_ADDR, 8'h5A);
        ex(4, 1);
        ex(5, 8'h5A);
        snap();
        // Write during busy must leave the pin alone
        i_host.wr(gpio_map_pkg::PIN10_FUNC_ADDR, a ^ 8'h80);
        repeat (8) @(posedge clk_i);
        ex(1, e10);
        snap();
        resetn_i <= 1'b0;
        repeat (2) @(posedge clk_i);
        resetn_i <= 1'b1;
        ex(4, 0);
        ex(5, 0);
        ex(3, ct);
        snap();
        rd(gpio_map_pkg::PIN10_FUNC_ADDR, 8'h00);
        end_sim();
    end
endmodule
